// ---- rtl/ctc_pkg.sv ----
// constants for the clock test, watchdog and low-voltage register block
// assumes a 100 MHz bus clock and an AXI4-Lite master with 32-bit data
package ctc_pkg;
    // register indices, byte address is four times the index
    localparam logic [11:0] IDX_FM_AMP = 12'h03E;
    localparam logic [11:0] IDX_WDOG_ARM = 12'h03F;
    localparam logic [11:0] IDX_LV_CTRL = 12'h2F1;
    localparam logic [11:0] IDX_PIRQ_CTRL = 12'h2F2;
    localparam logic [11:0] IDX_TEST_SEL = 12'h040;
    localparam logic [11:0] IDX_WDOG_CFG = 12'h041;
    localparam int ADDR_W = 14;
    // pll test control fields
    localparam int PT_PFD_EN = 7;
    localparam int PT_CLK_EN = 6;
    localparam int PT_SEL_HI = 5;
    localparam int PT_SEL_LO = 4;
    localparam int PT_MON_DIS = 3;
    localparam int PT_SQW = 2;
    localparam int PT_UP = 1;
    localparam int PT_DN = 0;
    // low-voltage control fields
    localparam int LV_STATUS = 2;
    localparam int LV_IE = 1;
    localparam int LV_FLAG = 0;
    // own configuration fields
    localparam int TS_FM_SEL = 0;
    localparam int WD_WINDOW = 7;
    localparam int WD_RATE_HI = 2;
    // reset values
    localparam logic [7:0] PT_RESET = 8'h00;
    localparam logic [7:0] FM_RESET = 8'h00;
    localparam logic [7:0] PIRQ_RESET = 8'h00;
    localparam logic [7:0] WDCFG_RESET = 8'h00;
    // watchdog keys
    localparam logic [7:0] WD_KEY_FIRST = 8'h55;
    localparam logic [7:0] WD_KEY_SECOND = 8'hAA;
    // triangle modulation step interval in cycles
    localparam logic [7:0] FM_STEP_CYCLES = 8'h10;
    // input settle cycles before the low-voltage status is trusted
    localparam logic [2:0] LV_SETTLE_CYCLES = 3'h5;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SRC_INTERNAL_RC,
        SRC_OSCILLATOR,
        SRC_VCO,
        SRC_VCO_QUARTER
    } ctc_test_src_t;
endpackage : ctc_pkg

// ---- rtl/ctc_watchdog.sv ----
// watchdog timeout counter with 0x55/0xAA restart and window mode
// assumes arm writes arrive as one-cycle pulses on the same clock
`timescale 1ns/10ps
module ctc_watchdog import ctc_pkg::*; #(
    parameter int BASE_LOG2 = 14
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration
    input wire logic [2:0] rateSelect,
    input wire logic windowMode,
    // arm register writes
    input wire logic armWrite,
    input wire logic [7:0] armData,
    // reset request
    output logic resetRequest
);
    if (BASE_LOG2 < 2 || BASE_LOG2 + 7 > 31) begin : g_chk
        $error("watchdog base exponent out of range");
    end

    logic [31:0] count_q;
    logic firstSeen_q;
    logic [31:0] timeoutLen;
    logic enabled;
    logic earlyWrite;
    logic timeout;
    logic badValue;
    logic restart;

    assign enabled = rateSelect != 3'h0;
    assign timeoutLen = 32'h1 << (BASE_LOG2 + int'(rateSelect));
    assign timeout = enabled && !restart && count_q == timeoutLen - 32'h1;
    assign earlyWrite = windowMode && count_q < timeoutLen - (timeoutLen >> 2);
    assign badValue = armData != WD_KEY_FIRST && armData != WD_KEY_SECOND;
    assign restart = enabled && armWrite && !earlyWrite && armData == WD_KEY_SECOND
        && firstSeen_q;

    // timeout counter, held clear while disabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 32'h0;
        end else if (!enabled || restart || timeout) begin
            count_q <= 32'h0;
        end else begin
            count_q <= count_q + 32'h1;
        end
    end

    // first key remembered until the second arrives
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            firstSeen_q <= 1'b0;
        end else if (!enabled || restart || timeout) begin
            firstSeen_q <= 1'b0;
        end else if (armWrite && armData == WD_KEY_FIRST) begin
            firstSeen_q <= 1'b1;
        end
    end

    // one reset request pulse for any cause
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resetRequest <= 1'b0;
        end else begin
            resetRequest <= timeout || (enabled && armWrite && (badValue || earlyWrite));
        end
    end

    a_disabled_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        rateSelect == 3'h0 && $past(rateSelect) == 3'h0 |-> !resetRequest)
        else $error("watchdog reset while disabled");
    a_bad_key_reset: assert property (@(posedge clk) disable iff (!rst_n)
        enabled && armWrite && badValue |=> resetRequest)
        else $error("illegal arm value did not reset");
    a_window_early: assert property (@(posedge clk) disable iff (!rst_n)
        enabled && windowMode && armWrite && count_q < (timeoutLen >> 1) |=> resetRequest)
        else $error("early window write did not reset");
    a_restart_pair: assert property (@(posedge clk) disable iff (!rst_n)
        restart |=> count_q == 32'h0 && !firstSeen_q && !resetRequest)
        else $error("key pair did not restart watchdog");
endmodule : ctc_watchdog

// ---- rtl/ctc_regs.sv ----
// clock test, watchdog arm and low-voltage register block, AXI4-Lite slave
// assumes one bus clock; analog status pins are asynchronous and get synchronised
`timescale 1ns/10ps
module ctc_regs import ctc_pkg::*; #(
    parameter int WDOG_BASE_LOG2 = 14
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // asynchronous status pins
    input wire logic specialMode,
    input wire logic oscillatorEnable,
    input wire logic supplyBelowLevel,
    input wire logic fullPerformanceMode,
    // pll and oscillator controls
    output logic pfdDisconnect,
    output logic chargePumpDriveDown,
    output logic chargePumpDriveUp,
    output logic testClockEnable,
    output logic [1:0] testClockSource,
    output logic clockMonitorEnable,
    output logic extSquareWaveEnable,
    output logic [7:0] modulationAmplitudeValue,
    // periodic interrupt control word
    output logic [7:0] periodicIrqControl,
    // low-voltage interrupt and watchdog reset
    output logic lowVoltageIrq,
    output logic watchdogResetRequest
);
    // synchronisers: three flops, change taken when second and third agree
    localparam int NSYNC = 4;
    logic [NSYNC-1:0] pinRaw;
    logic [NSYNC-1:0] pinSync;
    assign pinRaw = {fullPerformanceMode, supplyBelowLevel, oscillatorEnable, specialMode};
    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
        logic [2:0] stage_q;
        logic level_q;
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                stage_q <= 3'h0;
                level_q <= 1'b0;
            end else begin
                stage_q <= {stage_q[1:0], pinRaw[i]};
                if (stage_q[1] == stage_q[2]) begin
                    level_q <= stage_q[2];
                end
            end
        end
        assign pinSync[i] = level_q;
    end
    logic specialSync;
    logic oscEnSync;
    logic belowSync;
    logic fpmSync;
    assign specialSync = pinSync[0];
    assign oscEnSync = pinSync[1];
    assign belowSync = pinSync[2];
    assign fpmSync = pinSync[3];

    // write channel capture
    logic awHeld_q;
    logic wHeld_q;
    logic [11:0] wrIdx_q;
    logic [7:0] wrByte_q;
    logic wrLane_q;
    logic wrDo;
    assign wrDo = awHeld_q && wHeld_q && !s_axi_bvalid;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld_q <= 1'b0;
            s_axi_awready <= 1'b1;
            wrIdx_q <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            s_axi_awready <= 1'b0;
            wrIdx_q <= s_axi_awaddr[ADDR_W-1:2];
        end else if (wrDo) begin
            awHeld_q <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wHeld_q <= 1'b0;
            s_axi_wready <= 1'b1;
            wrByte_q <= 8'h00;
            wrLane_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            s_axi_wready <= 1'b0;
            wrByte_q <= s_axi_wdata[7:0];
            wrLane_q <= s_axi_wstrb[0];
        end else if (wrDo) begin
            wHeld_q <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    function automatic logic mapped(input logic [11:0] idx);
        return idx == IDX_FM_AMP || idx == IDX_WDOG_ARM || idx == IDX_LV_CTRL
            || idx == IDX_PIRQ_CTRL || idx == IDX_TEST_SEL || idx == IDX_WDOG_CFG;
    endfunction : mapped

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wrDo) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(wrIdx_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // per-register write strobes, low byte lane only
    logic wrOk;
    logic wrPllTest;
    logic wrFmAmp;
    logic wrArm;
    logic wrLv;
    logic wrPirq;
    logic wrTestSel;
    logic wrWdCfg;
    logic fmSelect_q;
    assign wrOk = wrDo && wrLane_q;
    assign wrPllTest = wrOk && wrIdx_q == IDX_FM_AMP && !fmSelect_q && specialSync;
    assign wrFmAmp = wrOk && wrIdx_q == IDX_FM_AMP && fmSelect_q && specialSync;
    assign wrArm = wrOk && wrIdx_q == IDX_WDOG_ARM;
    assign wrLv = wrOk && wrIdx_q == IDX_LV_CTRL;
    assign wrPirq = wrOk && wrIdx_q == IDX_PIRQ_CTRL;
    assign wrTestSel = wrOk && wrIdx_q == IDX_TEST_SEL && specialSync;
    assign wrWdCfg = wrOk && wrIdx_q == IDX_WDOG_CFG;

    // pll test control and amplitude storage
    logic [7:0] pllTest_q;
    logic [7:0] fmAmp_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pllTest_q <= PT_RESET;
        end else if (wrPllTest) begin
            pllTest_q <= wrByte_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fmAmp_q <= FM_RESET;
        end else if (wrFmAmp) begin
            fmAmp_q <= wrByte_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fmSelect_q <= 1'b0;
        end else if (wrTestSel) begin
            fmSelect_q <= wrByte_q[TS_FM_SEL];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            periodicIrqControl <= PIRQ_RESET;
        end else if (wrPirq) begin
            periodicIrqControl <= wrByte_q;
        end
    end

    logic [7:0] wdCfg_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdCfg_q <= WDCFG_RESET;
        end else if (wrWdCfg) begin
            wdCfg_q <= wrByte_q & {1'b1, 4'h0, 3'h7};
        end
    end

    // analog control outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pfdDisconnect <= 1'b0;
            chargePumpDriveDown <= 1'b0;
            chargePumpDriveUp <= 1'b0;
            testClockEnable <= 1'b0;
            testClockSource <= SRC_INTERNAL_RC;
            clockMonitorEnable <= 1'b0;
            extSquareWaveEnable <= 1'b0;
        end else begin
            pfdDisconnect <= pllTest_q[PT_PFD_EN];
            chargePumpDriveDown <= pllTest_q[PT_PFD_EN] && pllTest_q[PT_UP];
            chargePumpDriveUp <= pllTest_q[PT_PFD_EN] && pllTest_q[PT_DN];
            testClockEnable <= pllTest_q[PT_CLK_EN];
            testClockSource <= pllTest_q[PT_SEL_HI:PT_SEL_LO];
            clockMonitorEnable <= oscEnSync && !pllTest_q[PT_MON_DIS];
            extSquareWaveEnable <= pllTest_q[PT_SQW];
        end
    end

    // triangular sweep when the amplitude register is not selected
    logic [7:0] stepCnt_q;
    logic [7:0] tri_q;
    logic triDown_q;
    logic stepTick;
    assign stepTick = stepCnt_q == FM_STEP_CYCLES - 8'h01;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stepCnt_q <= 8'h00;
        end else begin
            stepCnt_q <= stepTick ? 8'h00 : stepCnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tri_q <= 8'h00;
            triDown_q <= 1'b0;
        end else if (stepTick) begin
            if (triDown_q) begin
                tri_q <= tri_q - 8'h01;
                triDown_q <= tri_q != 8'h01;
            end else begin
                tri_q <= tri_q + 8'h01;
                triDown_q <= tri_q == 8'hFE;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            modulationAmplitudeValue <= 8'h00;
        end else begin
            modulationAmplitudeValue <= fmSelect_q ? fmAmp_q : tri_q;
        end
    end

    // low-voltage status, flag and interrupt
    logic [2:0] settle_q;
    logic lvStatus_q;
    logic lvFlag_q;
    logic low_voltage_irq_enable_q;
    logic lvNow;
    logic lvChange;
    assign lvNow = belowSync && fpmSync;
    assign lvChange = settle_q == LV_SETTLE_CYCLES && lvNow != lvStatus_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            settle_q <= 3'h0;
            lvStatus_q <= 1'b0;
        end else if (settle_q != LV_SETTLE_CYCLES) begin
            settle_q <= settle_q + 3'h1;
            lvStatus_q <= lvNow;
        end else begin
            lvStatus_q <= lvNow;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lvFlag_q <= 1'b0;
        end else if (settle_q != LV_SETTLE_CYCLES) begin
            lvFlag_q <= lvNow;
        end else if (lvChange) begin
            lvFlag_q <= 1'b1;
        end else if (wrLv && wrByte_q[LV_FLAG]) begin
            lvFlag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_voltage_irq_enable_q <= 1'b0;
        end else if (wrLv) begin
            low_voltage_irq_enable_q <= wrByte_q[LV_IE];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lowVoltageIrq <= 1'b0;
        end else begin
            lowVoltageIrq <= low_voltage_irq_enable_q && lvFlag_q;
        end
    end

    // watchdog
    ctc_watchdog #(
        .BASE_LOG2(WDOG_BASE_LOG2)
    ) u_wdog (
        .clk(clk),
        .rst_n(rst_n),
        .rateSelect(wdCfg_q[WD_RATE_HI:0]),
        .windowMode(wdCfg_q[WD_WINDOW]),
        .armWrite(wrArm),
        .armData(wrByte_q),
        .resetRequest(watchdogResetRequest)
    );

    // read channel, one cycle after address accepted
    logic [11:0] rdIdx;
    logic [7:0] rdByte;
    assign rdIdx = s_axi_araddr[ADDR_W-1:2];
    always_comb begin
        rdByte = 8'h00;
        if (rdIdx == IDX_FM_AMP) begin
            rdByte = fmSelect_q ? fmAmp_q : pllTest_q;
        end else if (rdIdx == IDX_LV_CTRL) begin
            rdByte = {5'h00, lvStatus_q, low_voltage_irq_enable_q, lvFlag_q};
        end else if (rdIdx == IDX_PIRQ_CTRL) begin
            rdByte = periodicIrqControl;
        end else if (rdIdx == IDX_TEST_SEL) begin
            rdByte = {7'h00, fmSelect_q};
        end else if (rdIdx == IDX_WDOG_CFG) begin
            rdByte = wdCfg_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rdByte};
            s_axi_rresp <= mapped(rdIdx) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // checks
    sequence s_lv_change;
        lvChange;
    endsequence
    sequence s_flag_up;
        lvFlag_q ##1 (lvFlag_q || $past(wrLv && wrByte_q[LV_FLAG]));
    endsequence

    a_loop_open: assert property (@(posedge clk) disable iff (!rst_n)
        pllTest_q[PT_PFD_EN] |=> pfdDisconnect)
        else $error("loop not opened under override");
    a_force_gated: assert property (@(posedge clk) disable iff (!rst_n)
        (chargePumpDriveDown || chargePumpDriveUp) |-> $past(pllTest_q[PT_PFD_EN]))
        else $error("charge pump forced without override");
    a_monitor_off: assert property (@(posedge clk) disable iff (!rst_n)
        pllTest_q[PT_MON_DIS] ##1 pllTest_q[PT_MON_DIS] |-> !clockMonitorEnable)
        else $error("clock monitor running while disabled");
    a_amp_guard: assert property (@(posedge clk) disable iff (!rst_n)
        !specialSync |=> $stable(fmAmp_q) && $stable(pllTest_q))
        else $error("test register written outside special mode");
    a_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
        s_lv_change |=> s_flag_up)
        else $error("status change did not hold flag");
    a_irq_follow: assert property (@(posedge clk) disable iff (!rst_n)
        low_voltage_irq_enable_q && lvFlag_q |=> lowVoltageIrq)
        else $error("interrupt not requested with flag");
    a_irq_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        !low_voltage_irq_enable_q |=> !lowVoltageIrq)
        else $error("interrupt requested while disabled");
    a_arm_reads_zero: assert property (@(posedge clk) disable iff (!rst_n)
        s_axi_arvalid && s_axi_arready && rdIdx == IDX_WDOG_ARM
        |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
        else $error("arm register read nonzero");
    a_status_ro: assert property (@(posedge clk) disable iff (!rst_n)
        settle_q == LV_SETTLE_CYCLES |=> lvStatus_q == $past(lvNow))
        else $error("low-voltage status not tracking supply");
endmodule : ctc_regs

// ---- dv/tb_top.sv ----
// bench for the clock test, watchdog and low-voltage register block
// assumes the block as the only bus slave, pins driven straight by the bench
`timescale 1ns/10ps
module tb_top import ctc_pkg::*;;
    localparam logic [13:0] A_PT = {IDX_FM_AMP, 2'b00};
    localparam logic [13:0] A_ARM = {IDX_WDOG_ARM, 2'b00};
    localparam logic [13:0] A_LV = {IDX_LV_CTRL, 2'b00};
    localparam logic [13:0] A_PIRQ = {IDX_PIRQ_CTRL, 2'b00};
    localparam logic [13:0] A_SEL = {IDX_TEST_SEL, 2'b00};
    localparam logic [13:0] A_CFG = {IDX_WDOG_CFG, 2'b00};
    logic clk, rst_n, awValid, wValid, bReady, arValid, rReady;
    logic specMode, oscEn, supBelow, fullPerf;
    logic awReady, wReady, bValid, arReady, rValid, pfdOff, cpDown, cpUp;
    logic tstEn, monEn, sqwEn, lvIrq, wdReq;
    logic [13:0] awAddr, arAddr;
    logic [31:0] wData, rData;
    logic [3:0] wStrb;
    logic [1:0] bResp, rResp, tstSrc;
    logic [7:0] fmAmp, pirq, old;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    int wdPulses = 0;
    int p;

    ctc_regs #(.WDOG_BASE_LOG2(2)) dut_u (
        .clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .specialMode(specMode), .oscillatorEnable(oscEn),
        .supplyBelowLevel(supBelow), .fullPerformanceMode(fullPerf),
        .pfdDisconnect(pfdOff), .chargePumpDriveDown(cpDown), .chargePumpDriveUp(cpUp),
        .testClockEnable(tstEn), .testClockSource(tstSrc), .clockMonitorEnable(monEn),
        .extSquareWaveEnable(sqwEn), .modulationAmplitudeValue(fmAmp),
        .periodicIrqControl(pirq), .lowVoltageIrq(lvIrq), .watchdogResetRequest(wdReq)
    );

    always #5 clk = ~clk;

    always @(negedge clk) begin
        if (wdReq === 1'b1) wdPulses++;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // one write, ends at a falling edge with outputs settled
    task automatic wrc(input logic [13:0] a, input logic [7:0] d,
                       input logic [1:0] er = RESP_OKAY);
        logic pa, pw, ta, tw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge clk);
        awAddr <= a;
        wData <= {24'h0, d};
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (pa || pw) begin
            @(negedge clk);
            ta = pa && awReady;
            tw = pw && wReady;
            @(posedge clk);
            if (ta) awValid <= 1'b0;
            if (tw) wValid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        do @(negedge clk); while (bValid !== 1'b1);
        chk(32'(bResp), 32'(er));
        @(posedge clk);
        bReady <= 1'b0;
        @(negedge clk);
    endtask : wrc

    // one read compared with e
    task automatic rdc(input logic [13:0] a, input logic [7:0] e);
        logic pa;
        pa = 1'b1;
        @(posedge clk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        while (pa) begin
            @(negedge clk);
            pa = !arReady;
            @(posedge clk);
            if (!pa) arValid <= 1'b0;
        end
        do @(negedge clk); while (rValid !== 1'b1);
        chk(rData, {24'h0, e});
        chk(32'(rResp), 32'(RESP_OKAY));
        @(posedge clk);
        rReady <= 1'b0;
        @(negedge clk);
    endtask : rdc

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {awValid, wValid, bReady, arValid, rReady} = 5'h00;
        {awAddr, arAddr, wData} = '0;
        wStrb = 4'hF;
        {specMode, oscEn, supBelow, fullPerf} = 4'h5;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        rdc(A_PT, PT_RESET);
        rdc(A_LV, 8'h00);
        rdc(A_ARM, 8'h00);
        chk(32'({pfdOff, cpDown, cpUp, tstEn, monEn, sqwEn}), 32'h02);
        wrc(A_PT, 8'hFF);
        rdc(A_PT, 8'h00);
        @(posedge clk);
        specMode <= 1'b1;
        repeat (6) @(posedge clk);
        wrc(A_PT, 8'h82);
        chk(32'({pfdOff, cpDown, cpUp}), 32'h6);
        wrc(A_PT, 8'h81);
        chk(32'({pfdOff, cpDown, cpUp}), 32'h5);
        wrc(A_PT, 8'h03);
        chk(32'({pfdOff, cpDown, cpUp}), 32'h0);
        for (int s = 0; s < 4; s++) begin
            wrc(A_PT, 8'h44 | 8'(s << 4));
            chk(32'({tstEn, sqwEn, tstSrc}), 32'(s + 12));
        end
        wrc(A_PT, 8'h08);
        chk(32'({tstEn, monEn, sqwEn}), 32'h0);
        wrc(A_PIRQ, 8'hA5);
        wrc(14'h0200, 8'h12, RESP_SLVERR);
        rdc(A_PIRQ, 8'hA5);
        @(posedge clk);
        wStrb <= 4'hE;
        wrc(A_PIRQ, 8'h5A);
        @(posedge clk);
        wStrb <= 4'hF;
        rdc(A_PIRQ, 8'hA5);
        chk(32'(pirq), 32'hA5);
        wrc(A_SEL, 8'h01);
        wrc(A_PT, 8'h3C);
        rdc(A_PT, 8'h3C);
        chk(32'(fmAmp), 32'h3C);
        @(posedge clk);
        specMode <= 1'b0;
        repeat (6) @(posedge clk);
        wrc(A_PT, 8'h11);
        rdc(A_PT, 8'h3C);
        @(posedge clk);
        specMode <= 1'b1;
        repeat (6) @(posedge clk);
        wrc(A_SEL, 8'h00);
        rdc(A_PT, 8'h08);
        old = fmAmp;
        repeat (40) @(negedge clk);
        chk(32'(fmAmp !== old), 32'h1);
        p = wdPulses;
        wrc(A_ARM, 8'h12);
        repeat (4) @(negedge clk);
        chk(wdPulses, p);
        wrc(A_CFG, 8'h04);
        repeat (3) begin
            repeat (20) @(negedge clk);
            wrc(A_ARM, 8'h55);
            wrc(A_ARM, 8'h55);
            wrc(A_ARM, 8'hAA);
        end
        chk(wdPulses, p);
        repeat (70) @(negedge clk);
        chk(wdPulses, p + 1);
        wrc(A_ARM, 8'h12);
        repeat (3) @(negedge clk);
        chk(wdPulses, p + 2);
        wrc(A_CFG, 8'h00);
        wrc(A_CFG, 8'h84);
        wrc(A_ARM, 8'h55);
        repeat (3) @(negedge clk);
        chk(wdPulses, p + 3);
        wrc(A_CFG, 8'h00);
        wrc(A_CFG, 8'h84);
        repeat (50) @(negedge clk);
        wrc(A_ARM, 8'h55);
        wrc(A_ARM, 8'hAA);
        wrc(A_CFG, 8'h00);
        chk(wdPulses, p + 3);
        wrc(A_LV, 8'hFA);
        rdc(A_LV, 8'h02);
        @(posedge clk);
        supBelow <= 1'b1;
        repeat (6) @(posedge clk);
        rdc(A_LV, 8'h07);
        chk(32'(lvIrq), 32'h1);
        wrc(A_LV, 8'h06);
        rdc(A_LV, 8'h07);
        wrc(A_LV, 8'h03);
        rdc(A_LV, 8'h06);
        chk(32'(lvIrq), 32'h0);
        @(posedge clk);
        fullPerf <= 1'b0;
        repeat (6) @(posedge clk);
        rdc(A_LV, 8'h03);
        wrc(A_LV, 8'h01);
        @(posedge clk);
        fullPerf <= 1'b1;
        repeat (6) @(posedge clk);
        rdc(A_LV, 8'h05);
        chk(32'(lvIrq), 32'h0);
        end_sim();
    end
endmodule : tb_top
